// file: verilog/mba_arbiter.sv
`timescale 1ns/1ns
module mba_arbiter
  import mba_pkg::*;
#(
  parameter int ADDR_W       = 32,
  parameter int TIMEOUT_CLKS = PREEMPT_TIMEOUT_CLKS
)
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // Mode select
  input  wire logic [1:0]         arb_mode,
  // External masters: DMA, refresh, bus master
  input  wire logic [NUM_EXT-1:0] master_req,
  output logic [NUM_EXT-1:0]      master_grant_ack_n,
  output logic [NUM_EXT-1:0]      master_reset,
  // Processor handshake
  output logic                    bus_yield_request,
  output logic                    yield_acknowledge,
  output logic                    cpu_bus_want,
  // Processor core
  input  wire logic               cpu_access_pending,
  input  wire logic               cpu_cycle_active,
  input  wire logic [ADDR_W-1:0]  cpu_core_addr,
  output logic                    cpu_bus_oe,
  output logic [ADDR_W-1:0]       cpu_addr_out,
  output logic                    cpu_stall,
  // Snooping of system bus writes
  input  wire logic [ADDR_W-1:0]  cpu_addr_in,
  input  wire logic               snoop_write,
  output logic                    cpu_invalidate,
  output logic [ADDR_W-1:0]       cpu_invalidate_addr,
  // Status
  output logic [1:0]              bus_owner,
  output logic                    handover_busy
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************

  generate
    if (TIMEOUT_CLKS < 2 || TIMEOUT_CLKS > 65535)
    begin : g_bad_timeout
      $error("TIMEOUT_CLKS must lie in 2..65535");
    end
    if (ADDR_W < 1)
    begin : g_bad_addr
      $error("ADDR_W must be positive");
    end
  endgenerate

  localparam int TMR_W = $clog2(TIMEOUT_CLKS + 1);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  typedef enum logic [1:0] {
    ST_OWNED,
    ST_RECLAIM,
    ST_FORCE,
    ST_HANDOVER
  } mba_state_e;

  mba_state_e            state;
  logic [1:0]            owner;
  logic [1:0]            target;
  logic [2:0]            rot_ptr;
  logic [SLICE_W-1:0]    slice_cnt;
  logic [TMR_W-1:0]      timer;
  logic [2:0]            pulse_cnt;
  logic [NUM_CLASS-1:0]  req_vec;
  logic [NUM_CLASS-1:0]  others;
  logic                  owner_req;
  logic                  owner_idle;
  logic                  slice_over;
  logic                  policy_ok;
  logic                  switch_now;
  logic                  released;
  logic                  win_found;
  logic [1:0]            win_cls;
  logic [2:0]            win_pos;

  // Processor's want is sampled like every other request
  assign req_vec    = {cpu_bus_want, master_req};
  assign others     = req_vec & ~(4'h1 << owner);
  assign owner_req  = req_vec[owner];
  assign owner_idle = (owner != CLS_CPU) && !owner_req;
  assign slice_over = (slice_cnt == '0);

  // ****************************************************************
  // Winner selection
  // ****************************************************************

  // Slice length of a class
  function automatic logic [SLICE_W-1:0] slice_of(input logic [1:0] c);
    unique case (c)
      CLS_DMA:     slice_of = SLICE_DMA;
      CLS_REFRESH: slice_of = SLICE_REFRESH;
      CLS_MASTER:  slice_of = SLICE_MASTER;
      CLS_CPU:     slice_of = SLICE_CPU;
    endcase
  endfunction

  // Fixed order: lowest class index wins, DMA first
  // Rotating order: first requester from the pointer on
  always_comb
  begin
    logic [2:0] pos;
    logic [1:0] cls;
    pos       = 3'h0;
    cls       = 2'h0;
    win_found = 1'b0;
    win_cls   = CLS_CPU;
    win_pos   = rot_ptr;
    if (arb_mode == MODE_FIXED)
    begin
      for (int i = NUM_CLASS - 1; i >= 0; i--)
      begin
        if (others[i])
        begin
          win_found = 1'b1;
          win_cls   = 2'(i);
        end
      end
    end
    else
    begin
      for (int i = ROT_LEN - 1; i >= 0; i--)
      begin
        pos = 3'((32'(rot_ptr) + 32'(i)) % ROT_LEN);
        cls = ROT_SEQ[2*pos +: 2];
        if (others[cls])
        begin
          win_found = 1'b1;
          win_cls   = cls;
          win_pos   = pos;
        end
      end
    end
  end

  // When a request may take the bus from the holder
  always_comb
  begin
    unique case (arb_mode)
      MODE_FIXED,
      MODE_ROTATE:   policy_ok = 1'b1;
      MODE_SLICE:    policy_ok = slice_over || !owner_req;
      MODE_COMBINED: policy_ok = slice_over || !owner_req;
    endcase
  end

  // Holder keeps the bus while nobody else asks, if it is the processor or still requests
  assign switch_now = owner_idle || (win_found && policy_ok);

  // Holder has let go of the bus
  assign released = (owner == CLS_CPU) ? yield_acknowledge
                                       : !master_req[owner];

  // ****************************************************************
  // Ownership sequence
  // ****************************************************************

  // Take back, wait for release, then hand over
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state  <= ST_OWNED;
      owner  <= CLS_CPU;
      target <= CLS_CPU;
    end
    else
    begin
      unique case (state)
        ST_OWNED:
          if (switch_now)
          begin
            state  <= ST_RECLAIM;
            target <= win_found ? win_cls : CLS_CPU;
          end
        ST_RECLAIM:
          if (released)
            state <= ST_HANDOVER;
          else if (timer == TMR_W'(TIMEOUT_CLKS - 1) && owner != CLS_CPU)
            state <= ST_FORCE;
        ST_FORCE:
          if (pulse_cnt == 3'h1)
            state <= ST_HANDOVER;
        ST_HANDOVER:
        begin
          state <= ST_OWNED;
          // A target that gave up meanwhile falls back to the processor
          owner <= req_vec[target] ? target : CLS_CPU;
        end
      endcase
    end
  end

  // Preemption timer, counted from the take-back
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      timer <= '0;
    else if (state == ST_RECLAIM)
      timer <= timer + TMR_W'(1);
    else
      timer <= '0;
  end

  // Reset pulse to a holder that would not release
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pulse_cnt    <= 3'h0;
      master_reset <= '0;
    end
    else if (state == ST_RECLAIM && !released
             && timer == TMR_W'(TIMEOUT_CLKS - 1) && owner != CLS_CPU)
    begin
      pulse_cnt           <= RESET_PULSE_CLKS;
      master_reset[owner] <= 1'b1;
    end
    else if (state == ST_FORCE && pulse_cnt != 3'h1)
      pulse_cnt <= pulse_cnt - 3'h1;
    else
    begin
      pulse_cnt    <= 3'h0;
      master_reset <= '0;
    end
  end

  // ****************************************************************
  // Grants
  // ****************************************************************

  // External grant only in ST_OWNED, so at most one is low
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      master_grant_ack_n <= GRANT_N_RESET;
    else if (state == ST_OWNED && switch_now)
      master_grant_ack_n <= GRANT_N_RESET;
    else if (state == ST_HANDOVER && req_vec[target]
             && target != CLS_CPU)
    begin
      master_grant_ack_n         <= GRANT_N_RESET;
      master_grant_ack_n[target] <= 1'b0;
    end
  end

  // Processor is held off whenever it is not the holder
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      bus_yield_request <= 1'b0;
    else if (state == ST_OWNED && switch_now && owner == CLS_CPU)
      bus_yield_request <= 1'b1;
    else if (state == ST_HANDOVER)
      bus_yield_request <= req_vec[target] && target != CLS_CPU;
  end

  // ****************************************************************
  // Slice timing and rotation
  // ****************************************************************

  // Slice budget reloads at each handover, counts while held
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      slice_cnt <= SLICE_CPU;
    else if (state == ST_HANDOVER)
      slice_cnt <= slice_of(req_vec[target] ? target : CLS_CPU);
    else if (state == ST_OWNED && !slice_over)
      slice_cnt <= slice_cnt - SLICE_W'(1);
  end

  // Pointer moves past the slot just chosen, at take-back
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rot_ptr <= 3'h0;
    else if (state == ST_OWNED && switch_now && win_found)
      rot_ptr <= (win_pos == ROT_LAST) ? 3'h0 : win_pos + 3'h1;
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_owner     <= CLS_CPU;
      handover_busy <= 1'b0;
    end
    else
    begin
      bus_owner     <= owner;
      handover_busy <= (state != ST_OWNED);
    end
  end

  // ****************************************************************
  // Processor port
  // ****************************************************************

  // Processor yields on request and waits for its removal
  mba_cpu_port #(
    .ADDR_W (ADDR_W)
  ) u_cpu (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .bus_yield_request (bus_yield_request),
    .yield_acknowledge (yield_acknowledge),
    .cpu_bus_want      (cpu_bus_want),
    .access_pending    (cpu_access_pending),
    .cycle_active      (cpu_cycle_active),
    .core_addr         (cpu_core_addr),
    .bus_oe            (cpu_bus_oe),
    .addr_out          (cpu_addr_out),
    .stall             (cpu_stall),
    .addr_in           (cpu_addr_in),
    .snoop_write       (snoop_write),
    .invalidate        (cpu_invalidate),
    .invalidate_addr   (cpu_invalidate_addr)
  );

endmodule

// file: inc/mba_pkg.sv
// ****************************************************************
// Shared constants of the bus arbiter
// ****************************************************************
package mba_pkg;

  // Clock rate
  localparam int CLK_PERIOD_NS = 8;

  // Requester classes, also the bit index in the request vector
  localparam int       NUM_CLASS   = 4;
  localparam logic [1:0] CLS_DMA     = 2'h0;
  localparam logic [1:0] CLS_REFRESH = 2'h1;
  localparam logic [1:0] CLS_MASTER  = 2'h2;
  localparam logic [1:0] CLS_CPU     = 2'h3;
  localparam int       NUM_EXT     = 3;

  // Arbitration modes as driven on arb_mode
  localparam logic [1:0] MODE_FIXED    = 2'h0;
  localparam logic [1:0] MODE_ROTATE   = 2'h1;
  localparam logic [1:0] MODE_SLICE    = 2'h2;
  localparam logic [1:0] MODE_COMBINED = 2'h3;

  // Rotation: DMA holds every other slot for short latency
  localparam int        ROT_LEN = 6;
  localparam logic [2:0] ROT_LAST = 3'h5;
  localparam logic [11:0] ROT_SEQ =
    {CLS_CPU, CLS_DMA, CLS_MASTER, CLS_DMA, CLS_REFRESH, CLS_DMA};

  // Bus time per class in clocks, sized to priority and need
  localparam int        SLICE_W       = 8;
  localparam logic [7:0] SLICE_DMA     = 8'h10;
  localparam logic [7:0] SLICE_REFRESH = 8'h08;
  localparam logic [7:0] SLICE_MASTER  = 8'h20;
  localparam logic [7:0] SLICE_CPU     = 8'h40;

  // Preemption timeout before a holder is reset
  localparam int PREEMPT_TIMEOUT_NS   = 1000;
  localparam int PREEMPT_TIMEOUT_CLKS =
    (PREEMPT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Length of the reset pulse to a stuck holder
  localparam logic [2:0] RESET_PULSE_CLKS = 3'h4;

  // Reset values
  localparam logic [NUM_EXT-1:0] GRANT_N_RESET = 3'h7;

endpackage

// file: verilog/mba_cpu_port.sv
`timescale 1ns/1ns
// ****************************************************************
// Processor side of the yield handshake
// ****************************************************************
module mba_cpu_port
  import mba_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Handshake with the arbiter
  input  wire logic              bus_yield_request,
  output logic                   yield_acknowledge,
  output logic                   cpu_bus_want,
  // Processor core
  input  wire logic              access_pending,
  input  wire logic              cycle_active,
  input  wire logic [ADDR_W-1:0] core_addr,
  output logic                   bus_oe,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   stall,
  // Snooping of other masters' writes
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              snoop_write,
  output logic                   invalidate,
  output logic [ADDR_W-1:0]      invalidate_addr
);

  // Refuse an address width the port cannot carry
  generate
    if (ADDR_W < 1)
    begin : g_bad_addr
      $error("ADDR_W must be positive");
    end
  endgenerate

  logic may_own;

  // Owning needs both the request and the acknowledge low
  assign may_own = !bus_yield_request && !yield_acknowledge;

  // Acknowledge only once the running cycle has ended
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      yield_acknowledge <= 1'b0;
    else if (!bus_yield_request)
      yield_acknowledge <= 1'b0;
    else if (!cycle_active)
      yield_acknowledge <= 1'b1;
  end

  // Want flag follows pending external work
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cpu_bus_want <= 1'b0;
    else
      cpu_bus_want <= access_pending;
  end

  // Drive address, data and status only while owning
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_oe   <= 1'b0;
      addr_out <= '0;
    end
    else
    begin
      bus_oe   <= may_own;
      addr_out <= core_addr;
    end
  end

  // Core runs from its cache; halts only on an external access
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      stall <= 1'b0;
    else
      stall <= access_pending && !may_own;
  end

  // Address pins act as input for cache invalidation
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      invalidate      <= 1'b0;
      invalidate_addr <= '0;
    end
    else
    begin
      invalidate <= snoop_write && !may_own;
      if (snoop_write && !may_own)
        invalidate_addr <= addr_in;
    end
  end

endmodule

// file: verification/mba_arbiter_sva.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checks of the arbiter
// ****************************************************************
module mba_arbiter_sva
  import mba_pkg::*;
#(
  parameter int ADDR_W       = 32,
  parameter int TIMEOUT_CLKS = PREEMPT_TIMEOUT_CLKS
)
(
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               reset,
  // External masters
  input wire logic [NUM_EXT-1:0] master_req,
  input wire logic [NUM_EXT-1:0] master_grant_ack_n,
  input wire logic [NUM_EXT-1:0] master_reset,
  // Processor side
  input wire logic               bus_yield_request,
  input wire logic               yield_acknowledge,
  input wire logic               cpu_bus_want,
  input wire logic               cpu_access_pending,
  input wire logic               cpu_cycle_active,
  input wire logic               cpu_bus_oe,
  input wire logic               cpu_stall,
  input wire logic [ADDR_W-1:0]  cpu_addr_in,
  input wire logic               snoop_write,
  input wire logic               cpu_invalidate,
  input wire logic [ADDR_W-1:0]  cpu_invalidate_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Kick of a stuck holder: rise, four clocks high, then low
  sequence s_kick;
    $rose(|master_reset);
  endsequence
  sequence s_pulse;
    (|master_reset) [*4] ##1 !(|master_reset);
  endsequence

  a_one_owner: assert property ($onehot0(~master_grant_ack_n) &&
    !(cpu_bus_oe && !(&master_grant_ack_n)))
    else $error("two bus owners at once");
  a_grant_after_ack: assert property (!(&master_grant_ack_n) |->
    bus_yield_request && yield_acknowledge)
    else $error("grant without processor release");
  a_ack_follows: assert property (bus_yield_request && !cpu_cycle_active
    |=> yield_acknowledge)
    else $error("yield acknowledge late");
  a_ack_drops: assert property (!bus_yield_request |=> !yield_acknowledge)
    else $error("yield acknowledge kept");
  // Skip the first clock after reset, where the past is reset state
  a_oe_rule: assert property (!$past(reset) |-> cpu_bus_oe ==
    $past(!bus_yield_request && !yield_acknowledge))
    else $error("processor drivers wrong");
  a_want_follows: assert property (cpu_access_pending |=> cpu_bus_want)
    else $error("bus want missing");
  a_stall_idle: assert property (!cpu_access_pending |=> !cpu_stall)
    else $error("stall without access");
  // Snoop follows the live yield state, not the registered enable
  a_snoop_inval: assert property (snoop_write &&
    (bus_yield_request || yield_acknowledge) |=>
    cpu_invalidate && cpu_invalidate_addr == $past(cpu_addr_in))
    else $error("snooped write not invalidated");
  a_kick_len: assert property (s_kick |-> s_pulse)
    else $error("holder reset pulse length");

  // Holder giving up by dropping its request loses the grant next clock
  for (genvar k = 0; k < NUM_EXT; k++)
  begin : g_rel
    a_release_quick: assert property (!master_req[k] &&
      !master_grant_ack_n[k] |=> master_grant_ack_n[k])
      else $error("grant kept after release");
  end
endmodule

bind mba_arbiter mba_arbiter_sva #(
  .ADDR_W       (ADDR_W),
  .TIMEOUT_CLKS (TIMEOUT_CLKS)
) i_sva (
  .ref_clk             (ref_clk),
  .reset               (reset),
  .master_req          (master_req),
  .master_grant_ack_n  (master_grant_ack_n),
  .master_reset        (master_reset),
  .bus_yield_request   (bus_yield_request),
  .yield_acknowledge   (yield_acknowledge),
  .cpu_bus_want        (cpu_bus_want),
  .cpu_access_pending  (cpu_access_pending),
  .cpu_cycle_active    (cpu_cycle_active),
  .cpu_bus_oe          (cpu_bus_oe),
  .cpu_stall           (cpu_stall),
  .cpu_addr_in         (cpu_addr_in),
  .snoop_write         (snoop_write),
  .cpu_invalidate      (cpu_invalidate),
  .cpu_invalidate_addr (cpu_invalidate_addr)
);

// file: verification/mba_master_model.sv
`timescale 1ns/1ns
// ****************************************************************
// External masters: DMA, refresh, bus master
// ****************************************************************
module mba_master_model
  import mba_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // Bench control
  input  wire logic [NUM_EXT-1:0] start,
  input  wire logic [NUM_EXT-1:0] stuck,
  input  wire logic [7:0]         hold,
  // Arbiter side
  input  wire logic [NUM_EXT-1:0] master_grant_ack_n,
  input  wire logic [NUM_EXT-1:0] master_reset,
  output logic [NUM_EXT-1:0]      master_req
);
  logic [NUM_EXT-1:0] own;
  logic [7:0]         left [NUM_EXT];

  // One request machine per master; a stuck one ignores takeback
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      master_req <= '0;
      own        <= '0;
      for (int i = 0; i < NUM_EXT; i++)
        left[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < NUM_EXT; i++)
      begin
        if (master_reset[i])
        begin
          master_req[i] <= 1'b0;
          own[i]        <= 1'b0;
        end
        else if (start[i])
        begin
          master_req[i] <= 1'b1;
          left[i]       <= hold;
        end
        else if (master_req[i] && !master_grant_ack_n[i])
        begin
          // Bus used only while the grant stands
          own[i] <= 1'b1;
          if (left[i] == 8'h00)
            master_req[i] <= 1'b0;
          else
            left[i] <= left[i] - 8'h01;
        end
        else if (own[i] && !stuck[i])
        begin
          master_req[i] <= 1'b0;
          own[i]        <= 1'b0;
        end
      end
    end
  end
endmodule

// file: verification/mba_arbiter_bench.sv
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench of the arbiter
// ****************************************************************
module mba_arbiter_bench
  import mba_pkg::*;
;
  localparam int TO = 8;
  logic               ref_clk = 1'b0;
  logic               reset = 1'b1;
  logic [1:0]         arb_mode = MODE_FIXED;
  logic [NUM_EXT-1:0] master_req, grant_n, kick;
  logic [NUM_EXT-1:0] start = '0;
  logic [NUM_EXT-1:0] stuck = '0;
  logic [7:0]         hold = 8'h00;
  logic               pend = 1'b0;
  logic               active = 1'b0;
  logic               snoop_write = 1'b0;
  logic [31:0]        addr_in = 32'h0;
  logic [31:0]        addr_out, inval_addr;
  logic               yreq, yack, want, oe, stall, inval, busy;
  logic [1:0]         bus_owner;
  int                 err_count = 0;
  int                 cmp_count = 0;

  // Clock
  initial
  begin
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  mba_arbiter #(.ADDR_W(32), .TIMEOUT_CLKS(TO)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .arb_mode(arb_mode),
    .master_req(master_req), .master_grant_ack_n(grant_n),
    .master_reset(kick), .bus_yield_request(yreq),
    .yield_acknowledge(yack), .cpu_bus_want(want),
    .cpu_access_pending(pend), .cpu_cycle_active(active),
    .cpu_core_addr(32'h0000_C0DE), .cpu_bus_oe(oe),
    .cpu_addr_out(addr_out), .cpu_stall(stall),
    .cpu_addr_in(addr_in), .snoop_write(snoop_write),
    .cpu_invalidate(inval), .cpu_invalidate_addr(inval_addr),
    .bus_owner(bus_owner), .handover_busy(busy));

  mba_master_model i_masters (
    .ref_clk(ref_clk), .reset(reset), .start(start), .stuck(stuck),
    .hold(hold), .master_grant_ack_n(grant_n), .master_reset(kick),
    .master_req(master_req));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for grant s (0..2), processor drivers (3) or a kick (4)
  task automatic wait_for(input int s, output int n);
    n = 0;
    while (n < 600 && (s < 3 ? grant_n[s] !== 1'b0 :
           s == 3 ? oe !== 1'b1 : kick === 3'h0))
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("wait target reached", 32'h1, 32'(n < 600));
  endtask

  // One-clock start pulse to the chosen masters
  task automatic go(input logic [2:0] m, input logic [7:0] h);
    @(posedge ref_clk);
    start <= m;
    hold  <= h;
    @(posedge ref_clk);
    start <= 3'h0;
  endtask

  task automatic t_dma_walk();
    int n;
    @(posedge ref_clk);
    active <= 1'b1;
    go(3'h1, 8'h06);
    repeat (4) @(negedge ref_clk);
    chk("ack mid cycle", 32'h0, yack);
    chk("handover busy", 32'h1, busy);
    chk("grant early", 32'h1, grant_n[0]);
    @(posedge ref_clk);
    active <= 1'b0;
    pend   <= 1'b1;
    wait_for(0, n);
    chk("ack at grant", 32'h1, yack);
    chk("cpu floats", 32'h0, oe);
    @(posedge ref_clk);
    snoop_write <= 1'b1;
    addr_in     <= 32'h0000_1A40;
    @(posedge ref_clk);
    snoop_write <= 1'b0;
    @(negedge ref_clk);
    chk("invalidate", 32'h1, inval);
    chk("invalidate addr", 32'h0000_1A40, inval_addr);
    chk("bus want", 32'h1, want);
    chk("stall", 32'h1, stall);
    chk("owner", 32'(CLS_DMA), bus_owner);
    wait_for(3, n);
    chk("grants after return", 32'h7, grant_n);
    chk("busy after return", 32'h0, busy);
    @(posedge ref_clk);
    pend <= 1'b0;
  endtask

  // All three ask at once in every mode; fixed order checked exactly
  task automatic t_modes();
    int n;
    logic [2:0] seen;
    logic [5:0] ord;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge ref_clk);
      arb_mode <= m[1:0];
      seen = 3'h0;
      ord  = 6'h00;
      go(3'h7, 8'h04);
      for (n = 0; n < 600 && seen != 3'h7; n++)
      begin
        @(negedge ref_clk);
        for (int i = 0; i < 3; i++)
          if (grant_n[i] === 1'b0 && !seen[i])
          begin
            seen[i] = 1'b1;
            ord     = {ord[3:0], 2'(i)};
          end
      end
      chk("all served", 32'h7, seen);
      if (m == 0)
        chk("fixed order", 32'h06, ord);
      wait_for(3, n);
    end
  endtask

  // Holder that will not let go is reset, then the bus moves on
  task automatic t_stuck();
    int n;
    @(posedge ref_clk);
    arb_mode <= MODE_FIXED;
    stuck    <= 3'h4;
    go(3'h4, 8'hFF);
    wait_for(2, n);
    go(3'h1, 8'h04);
    wait_for(4, n);
    chk("kick delay ok", 32'h1, 32'(n >= TO && n <= TO + 5));
    chk("kick target", 32'h4, kick);
    wait_for(0, n);
    @(posedge ref_clk);
    stuck <= 3'h0;
    wait_for(3, n);
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(negedge ref_clk);
    chk("grants in reset", 32'(GRANT_N_RESET), grant_n);
    chk("owner in reset", 32'(CLS_CPU), bus_owner);
    chk("yield in reset", 32'h0, {yreq, yack, kick});
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("cpu drives", 32'h1, oe);
    chk("cpu address", 32'h0000_C0DE, addr_out);
    t_dma_walk();
    t_modes();
    t_stuck();
    finish_test();
  end

  // Hang guard, well past the expected run
  initial
  begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule
